//--- hdl/mmc_pkg.sv
// Constants, command codes and configuration types of the motion module command interpreter.
package mmc_pkg;
    localparam int CLK_HZ      = 20_000_000;
    localparam int BAUD        = 9600;
    localparam int BIT_CYC     = CLK_HZ / BAUD;
    localparam int TIMEOUT_MS  = 2500;
    localparam int TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
    localparam int SEC_S       = 1;
    localparam int SEC_CYC     = CLK_HZ * SEC_S;
    localparam int SEC_PER_MIN = 60;
    localparam int TW          = 13;
    localparam int CW          = 26;
    localparam int AW          = 4;

    localparam logic [7:0] CMD_RD_MOTION = 8'h61;
    localparam logic [7:0] CMD_RD_LIGHT  = 8'h62;
    localparam logic [7:0] CMD_RD_PINFN  = 8'h63;
    localparam logic [7:0] CMD_RD_ACT    = 8'h64;
    localparam logic [7:0] CMD_RD_HS     = 8'h65;
    localparam logic [7:0] CMD_RD_FREQ   = 8'h66;
    localparam logic [7:0] CMD_RD_HSLVL  = 8'h67;
    localparam logic [7:0] CMD_RD_THRESH = 8'h6C;
    localparam logic [7:0] CMD_RD_DIR    = 8'h76;
    localparam logic [7:0] CMD_WR_PINFN  = 8'h43;
    localparam logic [7:0] CMD_WR_ACT    = 8'h44;
    localparam logic [7:0] CMD_WR_HS     = 8'h45;
    localparam logic [7:0] CMD_WR_FREQ   = 8'h46;
    localparam logic [7:0] CMD_WR_HSLVL  = 8'h47;
    localparam logic [7:0] CMD_WR_THRESH = 8'h4C;
    localparam logic [7:0] CMD_WR_OUT    = 8'h4F;
    localparam logic [7:0] CMD_WR_DIR    = 8'h56;

    localparam logic [7:0] CH_Y     = 8'h59;
    localparam logic [7:0] CH_N     = 8'h4E;
    localparam logic [7:0] CH_U     = 8'h55;
    localparam logic [7:0] CH_M     = 8'h4D;
    localparam logic [7:0] CH_R     = 8'h52;
    localparam logic [7:0] CH_H     = 8'h48;
    localparam logic [7:0] CH_L     = 8'h4C;
    localparam logic [7:0] CH_A     = 8'h41;
    localparam logic [7:0] CH_PLUS  = 8'h2B;
    localparam logic [7:0] CH_MINUS = 8'h2D;
    localparam logic [7:0] CH_ACK   = 8'h06;
    localparam logic [7:0] CH_NACK  = 8'h15;
    localparam logic [7:0] LOWER_LO = 8'h61;
    localparam logic [7:0] LOWER_HI = 8'h7A;
    localparam logic [7:0] UPPER_LO = 8'h41;
    localparam logic [7:0] UPPER_HI = 8'h5A;
    localparam logic [7:0] ACT_MIN_BASE = 8'h80;
    localparam logic [7:0] HS_LVL_MAX   = 8'h03;

    localparam logic [AW-1:0] REG_STATUS = 4'h0;
    localparam logic [AW-1:0] REG_CFG    = 4'h4;
    localparam logic [AW-1:0] REG_MODE   = 4'h8;
    localparam int ST_STABLE_BIT = 0;
    localparam int ST_MOTION_BIT = 1;
    localparam int ST_ACTIVE_BIT = 2;
    localparam int ST_PINMD_BIT  = 3;
    localparam int ST_GATED_BIT  = 4;
    localparam int CFG_THR_LSB   = 0;
    localparam int CFG_ACT_LSB   = 8;

    typedef enum logic [1:0] {DIR_ANY = 2'h0, DIR_POS = 2'h1, DIR_NEG = 2'h2} mmc_dir_t;
    typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_TXV = 2'h1, ST_WAIT = 2'h3, ST_TXA = 2'h2} mmc_state_t;

    typedef struct packed {
        logic [7:0] thresh;
        logic [7:0] act_time;
        logic       pin_fn_md;
        logic       hs_en;
        logic [1:0] hs_level;
        logic       freq_high;
        mmc_dir_t   dir;
    } mmc_cfg_t;

    localparam mmc_cfg_t CFG_DEFAULT = '{thresh: 8'h64, act_time: 8'h02, pin_fn_md: 1'b0, hs_en: 1'b0,
                                         hs_level: 2'h1, freq_high: 1'b0, dir: DIR_ANY};
endpackage

//--- hdl/mmc_ser_if.sv
// Byte stream carrier between the command core and the serial line engine.
`timescale 1ns/10ps
interface mmc_ser_if;
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       tx_valid;
    logic [7:0] tx_data;
    logic       tx_ready;
    modport core (input rx_valid, rx_data, tx_ready, output tx_valid, tx_data);
    modport phy  (output rx_valid, rx_data, tx_ready, input tx_valid, tx_data);
endinterface

//--- hdl/mmc_uart.sv
// Serial line engine: 8 data bits, no parity, one stop bit, fixed baud.
`timescale 1ns/10ps
module mmc_uart (
    input  wire logic mclk_in,
    input  wire logic reset_in,
    input  wire logic rxd_in,
    output logic      txd_out,
    mmc_ser_if.phy    ser
);
    import mmc_pkg::*;
    localparam logic [11:0] BIT_LAST  = 12'(BIT_CYC - 1);
    localparam logic [11:0] HALF_LAST = 12'(BIT_CYC / 2 - 1);

    logic        rx_busy_q;
    logic [11:0] rx_cnt_q;
    logic [3:0]  rx_bit_q;
    logic [7:0]  rx_sh_q;
    logic        rx_vld_q;
    logic        tx_busy_q;
    logic [11:0] tx_cnt_q;
    logic [3:0]  tx_bit_q;
    logic [9:0]  tx_sh_q;

    wire rx_tick   = rx_busy_q && (rx_cnt_q == ((rx_bit_q == 4'h0) ? HALF_LAST : BIT_LAST));
    wire tx_tick   = tx_busy_q && (tx_cnt_q == BIT_LAST);
    wire tx_launch = ser.tx_valid && !tx_busy_q;

    assign ser.rx_valid = rx_vld_q;
    assign ser.rx_data  = rx_sh_q;
    assign ser.tx_ready = !tx_busy_q;

    // Start bit is checked at mid-bit so a glitch does not start a frame; stop bit must be high.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            rx_busy_q <= 1'b0;
            rx_cnt_q  <= 12'h000;
            rx_bit_q  <= 4'h0;
            rx_sh_q   <= 8'h00;
            rx_vld_q  <= 1'b0;
        end else begin
            rx_vld_q <= 1'b0;
            if (!rx_busy_q) begin
                rx_busy_q <= !rxd_in;
                rx_cnt_q  <= 12'h000;
                rx_bit_q  <= 4'h0;
            end else if (!rx_tick) begin
                rx_cnt_q <= rx_cnt_q + 12'h001;
            end else begin
                rx_cnt_q <= 12'h000;
                rx_bit_q <= rx_bit_q + 4'h1;
                if (rx_bit_q == 4'h0 && rxd_in) begin
                    rx_busy_q <= 1'b0;
                end else if (rx_bit_q == 4'h9) begin
                    rx_busy_q <= 1'b0;
                    rx_vld_q  <= rxd_in;
                end else if (rx_bit_q != 4'h0) begin
                    rx_sh_q <= {rxd_in, rx_sh_q[7:1]};
                end
            end
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            tx_busy_q <= 1'b0;
            tx_cnt_q  <= 12'h000;
            tx_bit_q  <= 4'h0;
            tx_sh_q   <= 10'h3FF;
        end else if (tx_launch) begin
            tx_busy_q <= 1'b1;
            tx_cnt_q  <= 12'h000;
            tx_bit_q  <= 4'h0;
            tx_sh_q   <= {1'b1, ser.tx_data, 1'b0};
        end else if (tx_tick) begin
            tx_cnt_q  <= 12'h000;
            tx_bit_q  <= tx_bit_q + 4'h1;
            tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
            tx_busy_q <= (tx_bit_q != 4'h9);
        end else if (tx_busy_q) begin
            tx_cnt_q <= tx_cnt_q + 12'h001;
        end
    end

    assign txd_out = tx_sh_q[0];
endmodule

//--- hdl/mmc_core.sv
// Command interpreter of the motion module: serial commands, settings, motion latch and output timing.
//Contract
// - Motion latches status Y until status read.
// - Status read returns value, then clears to N.
// - Unstable sensor makes status read return U.
// - Status read ignores output pin and timing.
// - Light level read returns input, 0 to 255.
// - Zero means most light, 255 least.
// - Level below threshold keeps motion output inactive.
// - Level above threshold lets output act normally.
// - Threshold written and read back, default 100.
// - Shared pin function M or R, default R.
// - Reset function: low pin resets whole module; code resets settings, sequencer, latch and timer, not UART.
// - Activation byte: 0/128 never, seconds, minutes.
// - Activation time written and read, default 2.
// - High sensitivity enable Y/N, default off.
// - High sensitivity level 0-3, default 1.
// - Level zero behaves as sensitivity disabled.
// - New level applies at once when enabled.
// - Frequency response H or L, default L.
// - Direction A, plus or minus, default A.
// - Output state command drives output directly; code loads the byte into the timer as activation time, light-gated.
// - Write returns current value, data timeout NACK.
// - Unknown or incomplete commands answered with NACK.
// - Lower case reads, upper case writes.
// - Link runs 9600 baud, 8N1, no flow.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module mmc_core #(
    parameter int TIMEOUT_CYC_P = mmc_pkg::TIMEOUT_CYC,
    parameter int SEC_CYC_P     = mmc_pkg::SEC_CYC
) (
    input  wire logic                mclk_in,
    input  wire logic                reset_in,
    input  wire logic                rxd_in,
    output logic                     txd_out,
    input  wire logic                md_pin_in,
    output logic                     md_pin_out,
    output logic                     md_pin_oe_out,
    input  wire logic [7:0]          light_level_in,
    input  wire logic                motion_evt_in,
    input  wire logic                sensor_stable_in,
    output logic [1:0]               hs_level_out,
    output logic                     freq_high_out,
    output mmc_pkg::mmc_dir_t        dir_out,
    output logic                     module_reset_out,
    input  wire logic [mmc_pkg::AW-1:0] reg_addr_in,
    input  wire logic [31:0]         reg_wdata_in,
    input  wire logic                reg_wr_in,
    input  wire logic                reg_rd_in,
    output logic [31:0]              reg_rdata_out
);
    import mmc_pkg::*;

    localparam logic [CW-1:0] TO_LAST  = CW'(TIMEOUT_CYC_P - 1);
    localparam logic [CW-1:0] SEC_LAST = CW'(SEC_CYC_P - 1);

    mmc_ser_if ser ();

    mmc_uart u_uart (
        .mclk_in  (mclk_in),
        .reset_in (reset_in),
        .rxd_in   (rxd_in),
        .txd_out  (txd_out),
        .ser      (ser)
    );

    mmc_state_t    st_q;
    mmc_cfg_t      cfg_q;
    mmc_cfg_t      cfg_new;
    logic [7:0]    cmd_q;
    logic [7:0]    tx_byte_q;
    logic [CW-1:0] to_q;
    logic [CW-1:0] sec_q;
    logic [TW-1:0] rem_q;
    logic          motion_q;
    logic          md_out_q;
    logic          soft_rst_q;
    logic [31:0]   rdata_q;
    logic [7:0]    rd_val;
    logic          rd_known;
    logic [7:0]    wr_cur;
    logic          wr_known;
    logic          data_ok;

    // Seconds for an activation byte; 0 and 128 mean the output is never raised.
    function automatic logic [TW-1:0] act_secs(input logic [7:0] b);
        logic [TW-1:0] m;
        m = TW'(b[6:0]);
        if (b[6:0] == 7'h00) begin
            act_secs = '0;
        end else if (b < ACT_MIN_BASE) begin
            act_secs = m;
        end else begin
            act_secs = TW'(m * TW'(SEC_PER_MIN));
        end
    endfunction

    wire rx_in     = ser.rx_valid;
    wire [7:0] rxb = ser.rx_data;
    wire is_lower  = (rxb >= LOWER_LO) && (rxb <= LOWER_HI);
    wire is_upper  = (rxb >= UPPER_LO) && (rxb <= UPPER_HI);
    wire cmd_take  = (st_q == ST_IDLE) && rx_in;
    wire data_take = (st_q == ST_WAIT) && rx_in;
    wire timeout   = (st_q == ST_WAIT) && !rx_in && (to_q == TO_LAST);
    wire rd_status = cmd_take && is_lower && (rxb == CMD_RD_MOTION);
    wire soft_rst  = !cfg_q.pin_fn_md && !md_pin_in;
    wire gated     = light_level_in < cfg_q.thresh;
    wire md_active = rem_q != '0;
    wire load_out  = data_take && (cmd_q == CMD_WR_OUT);
    wire [TW-1:0] trig_secs = act_secs(cfg_q.act_time);
    wire bus_cfg_wr = reg_wr_in && (reg_addr_in == REG_CFG);

    // Read answers are decoded only for lower-case letters; anything else falls to NACK.
    always_comb begin
        rd_known = is_lower;
        rd_val   = CH_NACK;
        case (rxb)
            CMD_RD_MOTION: rd_val = !sensor_stable_in ? CH_U : (motion_q ? CH_Y : CH_N);
            CMD_RD_LIGHT:  rd_val = light_level_in;
            CMD_RD_PINFN:  rd_val = cfg_q.pin_fn_md ? CH_M : CH_R;
            CMD_RD_ACT:    rd_val = cfg_q.act_time;
            CMD_RD_HS:     rd_val = cfg_q.hs_en ? CH_Y : CH_N;
            CMD_RD_FREQ:   rd_val = cfg_q.freq_high ? CH_H : CH_L;
            CMD_RD_HSLVL:  rd_val = {6'h00, cfg_q.hs_level};
            CMD_RD_THRESH: rd_val = cfg_q.thresh;
            CMD_RD_DIR:    rd_val = (cfg_q.dir == DIR_POS) ? CH_PLUS : ((cfg_q.dir == DIR_NEG) ? CH_MINUS : CH_A);
            default:       rd_known = 1'b0;
        endcase
    end

    always_comb begin
        wr_known = is_upper;
        wr_cur   = CH_NACK;
        case (rxb)
            CMD_WR_PINFN:  wr_cur = cfg_q.pin_fn_md ? CH_M : CH_R;
            CMD_WR_ACT:    wr_cur = cfg_q.act_time;
            CMD_WR_HS:     wr_cur = cfg_q.hs_en ? CH_Y : CH_N;
            CMD_WR_FREQ:   wr_cur = cfg_q.freq_high ? CH_H : CH_L;
            CMD_WR_HSLVL:  wr_cur = {6'h00, cfg_q.hs_level};
            CMD_WR_THRESH: wr_cur = cfg_q.thresh;
            CMD_WR_OUT:    wr_cur = {7'h00, md_active};
            CMD_WR_DIR:    wr_cur = (cfg_q.dir == DIR_POS) ? CH_PLUS : ((cfg_q.dir == DIR_NEG) ? CH_MINUS : CH_A);
            default:       wr_known = 1'b0;
        endcase
    end

    // A data byte outside the allowed set is refused and leaves the setting untouched.
    always_comb begin
        cfg_new = cfg_q;
        data_ok = 1'b1;
        case (cmd_q)
            CMD_WR_PINFN: begin
                data_ok           = (rxb == CH_M) || (rxb == CH_R);
                cfg_new.pin_fn_md = (rxb == CH_M);
            end
            CMD_WR_ACT:    cfg_new.act_time = rxb;
            CMD_WR_HS: begin
                data_ok       = (rxb == CH_Y) || (rxb == CH_N);
                cfg_new.hs_en = (rxb == CH_Y);
            end
            CMD_WR_FREQ: begin
                data_ok           = (rxb == CH_H) || (rxb == CH_L);
                cfg_new.freq_high = (rxb == CH_H);
            end
            CMD_WR_HSLVL: begin
                data_ok          = rxb <= HS_LVL_MAX;
                cfg_new.hs_level = rxb[1:0];
            end
            CMD_WR_THRESH: cfg_new.thresh = rxb;
            CMD_WR_DIR: begin
                data_ok     = (rxb == CH_A) || (rxb == CH_PLUS) || (rxb == CH_MINUS);
                cfg_new.dir = (rxb == CH_PLUS) ? DIR_POS : ((rxb == CH_MINUS) ? DIR_NEG : DIR_ANY);
            end
            default: data_ok = 1'b1;
        endcase
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            cfg_q <= CFG_DEFAULT;
        end else if (soft_rst) begin
            cfg_q <= CFG_DEFAULT;
        end else if (data_take && data_ok) begin
            cfg_q <= cfg_new;
        end else if (bus_cfg_wr) begin
            cfg_q.thresh   <= reg_wdata_in[CFG_THR_LSB +: 8];
            cfg_q.act_time <= reg_wdata_in[CFG_ACT_LSB +: 8];
        end
    end

    // Command sequencer: one answer per read or unknown command, a write answers twice around its data byte.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            st_q      <= ST_IDLE;
            cmd_q     <= 8'h00;
            tx_byte_q <= 8'h00;
        end else if (soft_rst) begin
            st_q <= ST_IDLE;
        end else begin
            case (st_q)
                ST_IDLE: if (rx_in) begin
                    cmd_q     <= rxb;
                    tx_byte_q <= wr_known ? wr_cur : (rd_known ? rd_val : CH_NACK);
                    st_q      <= wr_known ? ST_TXV : ST_TXA;
                end
                ST_TXV:  if (ser.tx_ready) begin
                    st_q <= ST_WAIT;
                end
                ST_WAIT: if (rx_in) begin
                    tx_byte_q <= data_ok ? CH_ACK : CH_NACK;
                    st_q      <= ST_TXA;
                end else if (timeout) begin
                    tx_byte_q <= CH_NACK;
                    st_q      <= ST_TXA;
                end
                ST_TXA:  if (ser.tx_ready) begin
                    st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    assign ser.tx_valid = (st_q == ST_TXV) || (st_q == ST_TXA);
    assign ser.tx_data  = tx_byte_q;

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            to_q <= '0;
        end else begin
            to_q <= (st_q == ST_WAIT) ? to_q + CW'(1) : '0;
        end
    end

    // A new event wins over the clearing read in the same cycle.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            motion_q <= 1'b0;
        end else if (soft_rst) begin
            motion_q <= 1'b0;
        end else begin
            motion_q <= motion_evt_in || (motion_q && !rd_status);
        end
    end

    // The remaining time counts in whole seconds; the output command overrides it and motion restarts it.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            rem_q <= '0;
            sec_q <= '0;
        end else if (soft_rst) begin
            rem_q <= '0;
            sec_q <= '0;
        end else if (load_out) begin
            rem_q <= act_secs(rxb);
            sec_q <= '0;
        end else if (motion_evt_in && trig_secs != '0) begin
            rem_q <= trig_secs;
            sec_q <= '0;
        end else if (md_active) begin
            sec_q <= (sec_q == SEC_LAST) ? '0 : sec_q + CW'(1);
            rem_q <= (sec_q == SEC_LAST) ? rem_q - TW'(1) : rem_q;
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            md_out_q   <= 1'b1;
            soft_rst_q <= 1'b0;
        end else begin
            md_out_q   <= !(md_active && !gated);
            soft_rst_q <= soft_rst;
        end
    end

    assign md_pin_out       = md_out_q;
    assign md_pin_oe_out    = cfg_q.pin_fn_md;
    assign module_reset_out = soft_rst_q;
    assign hs_level_out     = (cfg_q.hs_en && cfg_q.hs_level != 2'h0) ? cfg_q.hs_level : 2'h0;
    assign freq_high_out    = cfg_q.freq_high;
    assign dir_out          = cfg_q.dir;

    wire [31:0] st_word = 32'({gated, cfg_q.pin_fn_md, md_active, motion_q, sensor_stable_in});
    wire [31:0] cfg_word = {16'h0000, cfg_q.act_time, cfg_q.thresh};
    wire [31:0] mode_word = 32'({cfg_q.dir, cfg_q.freq_high, cfg_q.hs_level, cfg_q.hs_en});
    wire [31:0] rd_mux = (reg_addr_in == REG_STATUS) ? st_word :
                         (reg_addr_in == REG_CFG)    ? cfg_word :
                         (reg_addr_in == REG_MODE)   ? mode_word : 32'h0000_0000;

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= reg_rd_in ? rd_mux : 32'h0000_0000;
        end
    end

    assign reg_rdata_out = rdata_q;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    sequence status_read_s;
        rd_status && sensor_stable_in && !motion_evt_in && !soft_rst;
    endsequence

    motion_latch_a: assert property (motion_evt_in && !soft_rst |=> motion_q)
        else $error("motion event not latched");
    status_clear_a: assert property (status_read_s |=> !motion_q && tx_byte_q == ($past(motion_q) ? CH_Y : CH_N))
        else $error("status read did not return and clear");
    status_unstable_a: assert property (rd_status && !sensor_stable_in && !soft_rst |=> tx_byte_q == CH_U)
        else $error("unstable sensor did not answer U");
    gate_low_a: assert property (gated |=> md_pin_out)
        else $error("gated output went active");
    gate_open_a: assert property (md_active && !gated |=> !md_pin_out)
        else $error("ungated active output stayed inactive");
    light_read_a: assert property (cmd_take && rxb == CMD_RD_LIGHT && !soft_rst |=> tx_byte_q == $past(light_level_in))
        else $error("light level answer wrong");
    pin_reset_a: assert property (soft_rst |=> cfg_q == CFG_DEFAULT && st_q == ST_IDLE && module_reset_out)
        else $error("pin reset did not restore defaults");
    hs_zero_a: assert property (cfg_q.hs_level == 2'h0 || !cfg_q.hs_en |-> hs_level_out == 2'h0)
        else $error("level zero or disabled not off");
    unknown_nack_a: assert property (cmd_take && !rd_known && !wr_known && !soft_rst |=> tx_byte_q == CH_NACK && ser.tx_valid)
        else $error("unknown command not refused");
    data_timeout_a: assert property (timeout && !soft_rst |=> st_q == ST_TXA && tx_byte_q == CH_NACK)
        else $error("data timeout without NACK");
endmodule

//--- dv/mmc_host.sv
// Host model: sends command bytes on the serial line and collects the answer bytes.
`timescale 1ns/10ps
module mmc_host #(
    parameter int BIT_P = 2083
) (
    input  wire logic mclk_in,
    input  wire logic txd_in,
    output logic      rxd_out
);
    initial rxd_out = 1'b1;

    // Start bit, eight data bits LSB first, one stop bit; the line idles high.
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk_in) rxd_out <= frame[i];
            repeat (BIT_P - 1) @(posedge mclk_in);
        end
    endtask

    // Samples on the falling clock edge so the registered line has settled.
    task automatic recv_byte(output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        b = 8'h00;
        while (txd_in !== 1'b0 && n < 20 * BIT_P) begin
            @(negedge mclk_in);
            n++;
        end
        ok = (n < 20 * BIT_P);
        repeat (BIT_P + BIT_P / 2) @(negedge mclk_in);
        for (int i = 0; i < 8; i++) begin
            b[i] = txd_in;
            repeat (BIT_P) @(negedge mclk_in);
        end
        ok = ok && (txd_in === 1'b1);
    endtask
endmodule

//--- dv/mmc_core_bench.sv
// Self-checking bench of the command interpreter: register port, motion timing, gating, serial reads.
`timescale 1ns/10ps
module mmc_core_bench;
    import mmc_pkg::*;
    logic          mclk_in = 1'b0;
    logic          reset_in = 1'b1;
    logic          rxd, txd, pin_in, pin_out, pin_oe, evt, stable, freq_high, mod_rst, ok;
    logic [7:0]    light, ans;
    logic [1:0]    hs_level;
    mmc_dir_t      dir;
    logic [AW-1:0] addr;
    logic [31:0]   wdata, rdata;
    logic          wr, rd;
    int            err_count = 0;
    int            tests_run = 0;

    always #25 mclk_in = ~mclk_in;

    // Short second keeps timer runs within the cycle budget.
    mmc_core #(.TIMEOUT_CYC_P(30000), .SEC_CYC_P(100)) u_dut (.mclk_in(mclk_in), .reset_in(reset_in),
        .rxd_in(rxd), .txd_out(txd), .md_pin_in(pin_in), .md_pin_out(pin_out), .md_pin_oe_out(pin_oe),
        .light_level_in(light), .motion_evt_in(evt), .sensor_stable_in(stable), .hs_level_out(hs_level),
        .freq_high_out(freq_high), .dir_out(dir), .module_reset_out(mod_rst), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata));
    mmc_host u_host (.mclk_in(mclk_in), .txd_in(txd), .rxd_out(rxd));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [AW-1:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk_in);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [AW-1:0] a, input logic [31:0] exp);
        @(posedge mclk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_in);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic pulse;
        @(posedge mclk_in) evt <= 1'b1;
        @(posedge mclk_in) evt <= 1'b0;
    endtask
    // The answer starts before the command's stop bit ends, so both run at once.
    task automatic cmd(input logic [7:0] c);
        fork
            u_host.send_byte(c);
            u_host.recv_byte(ans, ok);
        join
        chk({31'h0, ok}, 32'h1);
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        pin_in = 1'b1;
        evt = 1'b0;
        stable = 1'b0;
        light = 8'h64;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        repeat (16) @(posedge mclk_in);
        reset_in <= 1'b0;
        @(posedge mclk_in);
        #1;
        chk({24'h0, hs_level, freq_high, dir, pin_oe, pin_out, mod_rst}, 32'h2);
        rd_chk(REG_CFG, 32'h0000_0264);
        rd_chk(4'hC, 32'h0);
        reg_wr(REG_STATUS, 32'hFF);
        rd_chk(REG_STATUS, 32'h0);
        @(posedge mclk_in);
        light <= 8'h63;
        stable <= 1'b1;
        pulse();
        rd_chk(REG_STATUS, 32'h17);
        chk({31'h0, pin_out}, 32'h1);
        @(posedge mclk_in);
        light <= 8'hC8;
        repeat (2) @(posedge mclk_in);
        #1;
        chk({31'h0, pin_out}, 32'h0);
        repeat (250) @(posedge mclk_in);
        #1;
        chk({31'h0, pin_out}, 32'h1);
        for (int i = 0; i < 2; i++) begin
            reg_wr(REG_CFG, 32'h64 | (32'(i) << 15));
            pulse();
            rd_chk(REG_STATUS, 32'h3);
        end
        reg_wr(REG_CFG, 32'h0000_8164);
        pulse();
        repeat (5900) @(posedge mclk_in);
        rd_chk(REG_STATUS, 32'h7);
        repeat (200) @(posedge mclk_in);
        rd_chk(REG_STATUS, 32'h3);
        cmd(CMD_RD_MOTION);
        chk({24'h0, ans}, {24'h0, CH_Y});
        rd_chk(REG_STATUS, 32'h1);
        @(posedge mclk_in);
        stable <= 1'b0;
        cmd(CMD_RD_MOTION);
        chk({24'h0, ans}, {24'h0, CH_U});
        reg_wr(REG_CFG, 32'h0000_1234);
        pin_in <= 1'b0;
        @(posedge mclk_in);
        #1;
        chk({31'h0, mod_rst}, 32'h1);
        @(posedge mclk_in);
        pin_in <= 1'b1;
        rd_chk(REG_CFG, 32'h0000_0264);
        print_verdict();
    end

    // The two serial reads take about 80000 cycles and the timer runs about 6500, so a hang stops soon after.
    initial begin
        repeat (95000) @(posedge mclk_in);
        err_count++;
        print_verdict();
    end
endmodule
